//--- inc/rmrd_pkg.sv
// package for the token-ring mac register bank: addresses, reset values, field layout, carriers
// assumes an 8-bit processor register address and 16-bit register words
package rmrd_pkg;
  localparam int RMRD_AW = 8;
  localparam int RMRD_DW = 16;
  localparam int RMRD_TW = 21;
  localparam int RMRD_LOW_W = 5;
  // processor register addresses
  localparam logic [7:0] A_CMD1_STATUS_ONE_UPPER = 8'h00;
  localparam logic [7:0] A_CMD2_STATUS_ONE_LOWER = 8'h01;
  localparam logic [7:0] A_STATUS_TWO_UPPER = 8'h02;
  localparam logic [7:0] A_STATUS_TWO_LOWER = 8'h03;
  localparam logic [7:0] A_MSK1U = 8'h04;
  localparam logic [7:0] A_MSK1L = 8'h05;
  localparam logic [7:0] A_MSK2U = 8'h06;
  localparam logic [7:0] A_MSK2L = 8'h07;
  localparam logic [7:0] A_SHORT_IND = 8'h08;
  localparam logic [7:0] A_LONG_IND_H = 8'h09;
  localparam logic [7:0] A_LONG_IND_M = 8'h0A;
  localparam logic [7:0] A_LONG_IND_L = 8'h0B;
  localparam logic [7:0] A_SHORT_GRP = 8'h0C;
  localparam logic [7:0] A_LONG_GRP_H = 8'h0D;
  localparam logic [7:0] A_LONG_GRP_M = 8'h0E;
  localparam logic [7:0] A_LONG_GRP_L = 8'h0F;
  localparam logic [7:0] A_CFG1 = 8'h10;
  localparam logic [7:0] A_STATE_REV = 8'h11;
  localparam logic [7:0] A_MIR_H = 8'h12;
  localparam logic [7:0] A_MIR_L = 8'h13;
  localparam logic [7:0] A_MAX_ROT = 8'h14;
  localparam logic [7:0] A_TVX = 8'h15;
  localparam logic [7:0] A_ROT_UP = 8'h16;
  localparam logic [7:0] A_HOLD_UP = 8'h17;
  localparam logic [7:0] A_NEG_UP = 8'h18;
  localparam logic [7:0] A_TMR_LOW = 8'h19;
  localparam logic [7:0] A_REQ_LO = 8'h1A;
  localparam logic [7:0] A_REQ_HI = 8'h1B;
  localparam logic [7:0] A_PRI0 = 8'h1C;
  localparam logic [7:0] A_PRI1 = 8'h1D;
  localparam logic [7:0] A_SYNC_BW = 8'h1F;
  localparam logic [7:0] A_CFG2 = 8'h20;
  localparam logic [7:0] A_FRM_THR = 8'h21;
  localparam logic [7:0] A_SYNC_LIM = 8'h40;
  localparam logic [7:0] A_CNT_FRAME = 8'h41;
  localparam logic [7:0] A_CNT_LOST = 8'h42;
  localparam logic [7:0] A_CNT_ERR = 8'h43;
  localparam logic [7:0] A_CNT_STRIP = 8'h44;
  localparam logic [7:0] A_CFG3 = 8'h60;
  localparam logic [7:0] A_STATUS_THREE_UPPER = 8'h61;
  localparam logic [7:0] A_STATUS_THREE_LOWER = 8'h62;
  localparam logic [7:0] A_MSK3U = 8'h63;
  localparam logic [7:0] A_MSK3L = 8'h64;
  localparam logic [7:0] A_INT_VEC = 8'h65;
  localparam logic [7:0] A_INT_SEL = 8'h66;
  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] RST_STATUS_ONE_LOWER = 16'h0007;
  localparam logic [15:0] RST_ST_UP = 16'h4000;
  localparam logic [15:0] RST_MASK = 16'hFFFF;
  localparam logic [15:0] RST_CFG1 = 16'h0080;
  localparam logic [15:0] RST_CFG2 = 16'h8000;
  localparam logic [15:0] RST_ROT_UP = 16'h03C7;
  localparam logic [15:0] RST_TVX = 16'h0085;
  localparam logic [15:0] RST_HOLD_UP = 16'hFFFF;
  localparam logic [4:0] RST_LOW_ZERO = 5'h00;
  localparam logic [4:0] RST_LOW_ONES = 5'h1F;
  localparam logic RST_LATE = 1'b1;
  localparam logic [15:0] RST_REQ_LO = 16'h78E0;
  localparam logic [4:0] RST_REQ_HI = 5'h00;
  localparam logic [15:0] RST_PRI = 16'hFFFF;
  localparam logic [15:0] RST_SYNC_LIM = 16'hFA97;
  // timer low-bits word and revision field layout
  localparam int TL_LATE = 15;
  localparam int TL_NEG_LSB = 10;
  localparam int TL_ROT_LSB = 5;
  localparam int TL_HOLD_LSB = 0;
  localparam int REV_LSB = 13;

  typedef struct packed {
    logic [5:0][15:0] event_mask; // index 0..5: one upper, one lower, two upper, two lower, three upper, three lower
    logic [15:0] short_ind;
    logic [47:0] long_ind;
    logic [15:0] short_grp;
    logic [47:0] long_grp;
    logic [15:0] config_one;
    logic [15:0] config_two;
    logic [15:0] config_three;
    logic [15:0] max_rotation;
    logic [15:0] tvx_limit;
    logic [15:0] req_rot_low;
    logic [4:0] req_rot_high;
    logic [15:0] async_pri0;
    logic [15:0] async_pri1;
    logic [15:0] sync_bw;
    logic [15:0] frame_thr;
    logic [15:0] sync_limit;
    logic [15:0] int_vector;
    logic [15:0] int_select;
  } rmrd_cfg_s;

  typedef struct packed {
    logic status_load;
    logic [5:0][15:0] status; // status_one_upper, status_one_lower, status_two_upper, status_two_lower, status_three_upper, status_three_lower
    logic timer_load;
    logic [20:0] rot_timer;
    logic [20:0] hold_timer;
    logic [20:0] neg_rotation;
    logic [15:0] tvx_timer;
    logic late_count;
    logic mir_load;
    logic [31:0] mir;
    logic [3:0] count_inc; // frame, lost, error, strip
  } rmrd_core_s;

  typedef struct packed {
    logic cmd_one_stb;
    logic [15:0] cmd_one;
    logic cmd_two_stb;
    logic [15:0] cmd_two;
  } rmrd_cmd_s;
endpackage

//--- tb/ring_mac_reset_defaults_tb_top.sv
// self-checking bench for the register bank: defaults, access kinds, command strobes, timer split, second reset
// assumes the node-processor model drives the register port and the bench drives the ring-core side
`timescale 1ns/1ps
module ring_mac_reset_defaults_tb_top;
  import rmrd_pkg::*;
  localparam logic [23:0] DFLT [36] = '{24'h000000, 24'h010007, 24'h024000, 24'h030000, 24'h04FFFF, 24'h05FFFF,
    24'h06FFFF, 24'h07FFFF, 24'h080000, 24'h0D0000, 24'h100080, 24'h11A000, 24'h120000, 24'h130000, 24'h1403C7,
    24'h150085, 24'h1603C7, 24'h17FFFF, 24'h1803C7, 24'h19801F, 24'h1A78E0, 24'h1B0000, 24'h1CFFFF, 24'h1DFFFF,
    24'h1F0000, 24'h208000, 24'h210000, 24'h40FA97, 24'h410000, 24'h440000, 24'h600000, 24'h614000, 24'h620000,
    24'h63FFFF, 24'h64FFFF, 24'h660000};
  localparam logic [7:0] RW_A [31] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
    8'h0F, 8'h10, 8'h14, 8'h15, 8'h1A, 8'h1C, 8'h1D, 8'h1F, 8'h20, 8'h21, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h60,
    8'h63, 8'h64, 8'h65, 8'h66};
  logic clock;
  logic sys_rst;
  logic [7:0] processor_register_address;
  logic np_wr;
  logic np_rd;
  logic [15:0] np_wdata;
  logic [15:0] np_rdata;
  logic np_rd_ack;
  rmrd_core_s core;
  rmrd_cfg_s cfg;
  rmrd_cmd_s cmd;
  logic [20:0] requested_rotation, sync_limit_timer, rotation_timer, holding_timer, negotiated_rotation;
  logic [15:0] tvx_timer;
  int miscompares;
  int checks_done;
  int cycles;
  rmrd_bank #(.REVISION(3'h5)) u_dut (.clock(clock), .sys_rst(sys_rst), .processor_register_address(processor_register_address),
    .np_wr(np_wr), .np_rd(np_rd), .np_wdata(np_wdata), .np_rdata(np_rdata), .np_rd_ack(np_rd_ack), .core(core), .cfg(cfg),
    .cmd(cmd), .requested_rotation(requested_rotation), .sync_limit_timer(sync_limit_timer), .rotation_timer(rotation_timer),
    .holding_timer(holding_timer), .negotiated_rotation(negotiated_rotation), .tvx_timer(tvx_timer));
  rmrd_np_model u_np (.clock(clock), .processor_register_address(processor_register_address), .np_wr(np_wr),
    .np_rd(np_rd), .np_wdata(np_wdata), .np_rdata(np_rdata), .np_rd_ack(np_rd_ack));
  always #2 clock = ~clock;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    u_np.read_reg(a, d, ok);
    check({15'h0000, ok, d}, {15'h0000, 1'b1, exp});
  endtask
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic t_defaults();
    for (int i = 0; i < 36; i++) chk_rd(DFLT[i][23:16], DFLT[i][15:0]);
    check({11'h000, sync_limit_timer}, {11'h000, 16'hFA97, 5'h00});
    check({11'h000, rotation_timer}, {11'h000, 16'h03C7, 5'h00});
  endtask
  task automatic t_access();
    for (int i = 0; i < 31; i++) u_np.write_reg(RW_A[i], 16'hA5C3 ^ {8'h00, RW_A[i]});
    for (int i = 0; i < 31; i++) chk_rd(RW_A[i], 16'hA5C3 ^ {8'h00, RW_A[i]});
    u_np.write_reg(8'h1B, 16'hFFFF);
    chk_rd(8'h1B, 16'h001F);
    u_np.write_reg(8'h16, 16'h1234);
    u_np.write_reg(8'h19, 16'h1234);
    u_np.write_reg(8'h50, 16'h1234);
    u_np.write_reg(8'h61, 16'h1234);
    chk_rd(8'h16, 16'h03C7);
    chk_rd(8'h19, 16'h801F);
    chk_rd(8'h50, 16'h0000);
    chk_rd(8'h61, 16'h4000);
  endtask
  task automatic t_command();
    u_np.write_reg(8'h00, 16'h1234);
    check({15'h0000, cmd.cmd_one_stb, cmd.cmd_one}, 32'h0001_1234);
    u_np.write_reg(8'h01, 16'h5678);
    check({15'h0000, cmd.cmd_two_stb, cmd.cmd_two}, 32'h0001_5678);
    chk_rd(8'h00, 16'h0000);
    chk_rd(8'h01, 16'h0007);
  endtask
  task automatic t_core_load();
    logic [20:0] r, h, n;
    r = 21'h15A5A5;
    h = 21'h0F0F1E;
    n = 21'h1C3E7B;
    @(posedge clock);
    #1;
    core.timer_load = 1'b1;
    core.rot_timer = r;
    core.hold_timer = h;
    core.neg_rotation = n;
    core.late_count = 1'b0;
    core.status_load = 1'b1;
    core.status[0] = 16'h1357;
    core.status[1] = 16'h2468;
    core.mir_load = 1'b1;
    core.mir = 32'h89AB_CDEF;
    core.count_inc = 4'h3;
    @(posedge clock);
    #1;
    core.timer_load = 1'b0;
    core.status_load = 1'b0;
    core.mir_load = 1'b0;
    core.count_inc = 4'h0;
    chk_rd(8'h12, 16'h89AB);
    chk_rd(8'h13, 16'hCDEF);
    chk_rd(8'h41, (16'hA5C3 ^ 16'h0041) + 16'h0001);
    chk_rd(8'h42, (16'hA5C3 ^ 16'h0042) + 16'h0001);
    chk_rd(8'h16, r[20:5]);
    chk_rd(8'h17, h[20:5]);
    chk_rd(8'h18, n[20:5]);
    chk_rd(8'h19, {1'b0, n[4:0], r[4:0], h[4:0]});
    chk_rd(8'h00, 16'h1357);
    chk_rd(8'h01, 16'h2468);
  endtask
  task automatic t_rereset();
    @(posedge clock);
    #1;
    sys_rst = 1'b1;
    repeat (2) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    for (int i = 0; i < 36; i++) chk_rd(DFLT[i][23:16], DFLT[i][15:0]);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_of_test();
    end
  end
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    core = '0;
    miscompares = 0;
    checks_done = 0;
    cycles = 0;
    repeat (20) @(posedge clock);
    #1;
    sys_rst = 1'b0;
    t_defaults();
    t_access();
    t_command();
    t_core_load();
    t_rereset();
    end_of_test();
  end
endmodule // ring_mac_reset_defaults_tb_top

//--- tb/rmrd_bank_checker.sv
// checker for the register bank: reset defaults, read timing, command strobes, timer word split
// assumes it is bound to rmrd_bank and sees only that module's ports
`timescale 1ns/1ps
module rmrd_bank_checker
  import rmrd_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] processor_register_address,
  input wire logic np_wr,
  input wire logic np_rd,
  input wire logic [15:0] np_wdata,
  input wire logic [15:0] np_rdata,
  input wire logic np_rd_ack,
  input wire rmrd_core_s core,
  input wire rmrd_cfg_s cfg,
  input wire rmrd_cmd_s cmd,
  input wire logic [20:0] requested_rotation,
  input wire logic [20:0] sync_limit_timer,
  input wire logic [20:0] rotation_timer,
  input wire logic [20:0] holding_timer,
  input wire logic [20:0] negotiated_rotation,
  input wire logic [15:0] tvx_timer
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // slices kept as nets so that $past sees a whole signal
  logic [14:0] low_pack;
  logic [15:0] rot_up;
  logic [15:0] neg_up;
  assign low_pack = {negotiated_rotation[4:0], rotation_timer[4:0], holding_timer[4:0]};
  assign rot_up = rotation_timer[20:5];
  assign neg_up = negotiated_rotation[20:5];
  sequence rd_of(logic [7:0] a);
    np_rd && processor_register_address == a;
  endsequence
  sequence wr_of(logic [7:0] a);
    np_wr && processor_register_address == a;
  endsequence
  rst_timer_a: assert property ($fell(sys_rst) |-> rotation_timer == {16'h03C7, 5'h00} && tvx_timer == 16'h0085
    && holding_timer == {16'hFFFF, 5'h1F} && negotiated_rotation == {16'h03C7, 5'h00} && cfg.tvx_limit == 16'h0085)
    else $error("timer defaults wrong after reset");
  rst_cfg_a: assert property ($fell(sys_rst) |-> cfg.event_mask == {6{16'hFFFF}} && cfg.max_rotation == 16'h03C7
    && requested_rotation == 21'h0078E0 && sync_limit_timer == {16'hFA97, 5'h00}) else $error("config defaults wrong");
  rst_quiet_a: assert property ($fell(sys_rst) |-> !np_rd_ack && cmd == '0) else $error("outputs not idle after reset");
  cmd_one_a: assert property (wr_of(8'h00) |=> cmd.cmd_one_stb && cmd.cmd_one == $past(np_wdata))
    else $error("command one not loaded");
  cmd_two_a: assert property (wr_of(8'h01) |=> cmd.cmd_two_stb && cmd.cmd_two == $past(np_wdata))
    else $error("command two not loaded");
  stb_cause_a: assert property (cmd.cmd_two_stb |-> $past(np_wr) && $past(processor_register_address) == 8'h01)
    else $error("command two strobe without write");
  low_split_a: assert property (rd_of(8'h19) |=> np_rd_ack && np_rdata[14:0] == $past(low_pack))
    else $error("timer low-bits word packed wrongly");
  rot_read_a: assert property (rd_of(8'h16) |=> np_rd_ack && np_rdata == $past(rot_up)) else $error("rotation upper word wrong");
  neg_read_a: assert property (rd_of(8'h18) |=> np_rdata == $past(neg_up)) else $error("negotiated upper word wrong");
  req_high_a: assert property (wr_of(8'h1B) |=> {11'h000, requested_rotation[20:16]} == ($past(np_wdata) & 16'h001F))
    else $error("requested rotation high word wrong");
  rev_zero_a: assert property (rd_of(8'h11) |=> np_rdata[12:0] == 13'h0000) else $error("state register low bits not zero");
  ack_timing_a: assert property (np_rd_ack == $past(np_rd)) else $error("read acknowledge not one cycle after strobe");
endmodule // rmrd_bank_checker

bind rmrd_bank rmrd_bank_checker u_chk (.clock(clock), .sys_rst(sys_rst), .processor_register_address(processor_register_address),
  .np_wr(np_wr), .np_rd(np_rd), .np_wdata(np_wdata), .np_rdata(np_rdata), .np_rd_ack(np_rd_ack), .core(core), .cfg(cfg),
  .cmd(cmd), .requested_rotation(requested_rotation), .sync_limit_timer(sync_limit_timer), .rotation_timer(rotation_timer),
  .holding_timer(holding_timer), .negotiated_rotation(negotiated_rotation), .tvx_timer(tvx_timer));

//--- tb/rmrd_np_model.sv
// node-processor model: one-cycle write and read strobes on the register address bus
// assumes the bank answers a read with an acknowledge registered on the edge that takes the strobe
`timescale 1ns/1ps
module rmrd_np_model (
  input wire logic clock,
  output logic [7:0] processor_register_address,
  output logic np_wr,
  output logic np_rd,
  output logic [15:0] np_wdata,
  input wire logic [15:0] np_rdata,
  input wire logic np_rd_ack
);
  initial begin
    processor_register_address = 8'h00;
    np_wr = 1'b0;
    np_rd = 1'b0;
    np_wdata = 16'h0000;
  end
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    processor_register_address = a;
    np_wdata = d;
    np_wr = 1'b1;
    @(posedge clock);
    #1;
    np_wr = 1'b0;
    // stale data is inverted so a late sample cannot pass by luck
    np_wdata = ~d;
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d, output logic ok);
    @(posedge clock);
    #1;
    processor_register_address = a;
    np_rd = 1'b1;
    @(posedge clock);
    #1;
    np_rd = 1'b0;
    ok = np_rd_ack;
    d = np_rdata;
  endtask
endmodule // rmrd_np_model

//--- verilog/rmrd_bank.sv
// register bank of the token-ring mac as seen by the node processor, with its power-up defaults
// assumes the ring core drives status, timers and counter pulses synchronously to clock
// Notes on behaviour
// - reset loads every timer and register of the bank with its fixed default.
// - after reset the valid-transmission register and its timer hold 85h.
// - after reset the rotation timer's readable upper word, bits 20 to 5, reads 03C7h.
// - after reset the negotiated-rotation upper word, bits 20 to 5, holds 03C7h.
// - reset clears the low five bits of the rotation timer and of the sync-limit timer.
// - after reset the holding timer upper word is FFFFh and its low five bits are all ones.
// - after reset the requested-rotation high word reads 0000h and only its low five bits carry value.
// - after reset every event-mask half-word reads FFFFh, status one lower 0007h, status two and three upper 4000h.
// - after reset the max-rotation register holds 03C7h and requested-rotation low holds 78E0h.
// - the timer low-bits word packs late count in 15, negotiated low bits 14-10, rotation 9-5, holding 4-0.
// - addresses 00 and 01 load the two command registers on write and return status one upper and lower on read.
`timescale 1ns/1ps
module rmrd_bank
  import rmrd_pkg::*;
#(
  parameter logic [2:0] REVISION = 3'h1 // arbitrary value
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] processor_register_address,
  input wire logic np_wr,
  input wire logic np_rd,
  input wire logic [15:0] np_wdata,
  output logic [15:0] np_rdata,
  output logic np_rd_ack,
  input wire rmrd_core_s core,
  output rmrd_cfg_s cfg,
  output rmrd_cmd_s cmd,
  output logic [20:0] requested_rotation,
  output logic [20:0] sync_limit_timer,
  output logic [20:0] rotation_timer,
  output logic [20:0] holding_timer,
  output logic [20:0] negotiated_rotation,
  output logic [15:0] tvx_timer
);

  typedef struct packed {
    rmrd_cfg_s cfg;
    rmrd_cmd_s cmd;
    logic [5:0][15:0] status;
    logic [20:0] rot;
    logic [20:0] hold;
    logic [20:0] neg;
    logic [15:0] tvx_tmr;
    logic late;
    logic [31:0] mir;
    logic [3:0][15:0] count;
    logic [15:0] rdata;
    logic rd_ack;
  } rmrd_state_s;

  rmrd_state_s state_r;
  rmrd_state_s state_nxt;
  logic [15:0] read_word;
  logic [15:0] timer_low_word;
  logic [15:0] revision_word;

  // only three bits exist for the revision field
  if ($bits(REVISION) != RMRD_DW - REV_LSB) begin : g_rev_check
    $error("revision field must be three bits wide");
  end

  // packed low bits of the three protocol timers
  always_comb begin
    timer_low_word = RST_ZERO;
    timer_low_word[TL_LATE] = state_r.late;
    timer_low_word[TL_NEG_LSB +: RMRD_LOW_W] = state_r.neg[RMRD_LOW_W-1:0];
    timer_low_word[TL_ROT_LSB +: RMRD_LOW_W] = state_r.rot[RMRD_LOW_W-1:0];
    timer_low_word[TL_HOLD_LSB +: RMRD_LOW_W] = state_r.hold[RMRD_LOW_W-1:0];
  end

  // the protocol state field is not modelled here, so only the revision shows
  always_comb begin
    revision_word = RST_ZERO;
    revision_word[RMRD_DW-1:REV_LSB] = REVISION;
  end

  // read multiplexer; unmapped addresses read as zero, command addresses 00 and 01 return status one
  always_comb begin
    case (processor_register_address)
      A_CMD1_STATUS_ONE_UPPER: read_word = state_r.status[0];
      A_CMD2_STATUS_ONE_LOWER: read_word = state_r.status[1];
      A_STATUS_TWO_UPPER: read_word = state_r.status[2];
      A_STATUS_TWO_LOWER: read_word = state_r.status[3];
      A_STATUS_THREE_UPPER: read_word = state_r.status[4];
      A_STATUS_THREE_LOWER: read_word = state_r.status[5];
      A_MSK1U: read_word = state_r.cfg.event_mask[0];
      A_MSK1L: read_word = state_r.cfg.event_mask[1];
      A_MSK2U: read_word = state_r.cfg.event_mask[2];
      A_MSK2L: read_word = state_r.cfg.event_mask[3];
      A_MSK3U: read_word = state_r.cfg.event_mask[4];
      A_MSK3L: read_word = state_r.cfg.event_mask[5];
      A_SHORT_IND: read_word = state_r.cfg.short_ind;
      A_LONG_IND_H: read_word = state_r.cfg.long_ind[47:32];
      A_LONG_IND_M: read_word = state_r.cfg.long_ind[31:16];
      A_LONG_IND_L: read_word = state_r.cfg.long_ind[15:0];
      A_SHORT_GRP: read_word = state_r.cfg.short_grp;
      A_LONG_GRP_H: read_word = state_r.cfg.long_grp[47:32];
      A_LONG_GRP_M: read_word = state_r.cfg.long_grp[31:16];
      A_LONG_GRP_L: read_word = state_r.cfg.long_grp[15:0];
      A_CFG1: read_word = state_r.cfg.config_one;
      A_CFG2: read_word = state_r.cfg.config_two;
      A_CFG3: read_word = state_r.cfg.config_three;
      A_STATE_REV: read_word = revision_word;
      A_MIR_H: read_word = state_r.mir[31:16];
      A_MIR_L: read_word = state_r.mir[15:0];
      A_MAX_ROT: read_word = state_r.cfg.max_rotation;
      A_TVX: read_word = state_r.cfg.tvx_limit;
      A_ROT_UP: read_word = state_r.rot[RMRD_TW-1:RMRD_LOW_W];
      A_HOLD_UP: read_word = state_r.hold[RMRD_TW-1:RMRD_LOW_W];
      A_NEG_UP: read_word = state_r.neg[RMRD_TW-1:RMRD_LOW_W];
      A_TMR_LOW: read_word = timer_low_word;
      A_REQ_LO: read_word = state_r.cfg.req_rot_low;
      A_REQ_HI: read_word = {11'h000, state_r.cfg.req_rot_high};
      A_PRI0: read_word = state_r.cfg.async_pri0;
      A_PRI1: read_word = state_r.cfg.async_pri1;
      A_SYNC_BW: read_word = state_r.cfg.sync_bw;
      A_FRM_THR: read_word = state_r.cfg.frame_thr;
      A_SYNC_LIM: read_word = state_r.cfg.sync_limit;
      A_CNT_FRAME: read_word = state_r.count[0];
      A_CNT_LOST: read_word = state_r.count[1];
      A_CNT_ERR: read_word = state_r.count[2];
      A_CNT_STRIP: read_word = state_r.count[3];
      A_INT_VEC: read_word = state_r.cfg.int_vector;
      A_INT_SEL: read_word = state_r.cfg.int_select;
      default: read_word = RST_ZERO;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    state_nxt.cmd.cmd_one_stb = 1'b0;
    state_nxt.cmd.cmd_two_stb = 1'b0;
    state_nxt.rd_ack = np_rd;
    if (np_rd) begin
      state_nxt.rdata = read_word;
    end
    // core-side updates first, so a processor write in the same cycle lands on top
    if (core.status_load) begin
      state_nxt.status = core.status;
    end
    if (core.timer_load) begin
      state_nxt.rot = core.rot_timer;
      state_nxt.hold = core.hold_timer;
      state_nxt.neg = core.neg_rotation;
      state_nxt.tvx_tmr = core.tvx_timer;
      state_nxt.late = core.late_count;
    end
    if (core.mir_load) begin
      state_nxt.mir = core.mir;
    end
    for (int i = 0; i < 4; i++) begin
      state_nxt.count[i] = state_r.count[i] + {15'h0000, core.count_inc[i]};
    end
    if (np_wr) begin
      case (processor_register_address)
        A_CMD1_STATUS_ONE_UPPER: begin
          state_nxt.cmd.cmd_one = np_wdata;
          state_nxt.cmd.cmd_one_stb = 1'b1;
        end
        A_CMD2_STATUS_ONE_LOWER: begin
          state_nxt.cmd.cmd_two = np_wdata;
          state_nxt.cmd.cmd_two_stb = 1'b1;
        end
        A_MSK1U: state_nxt.cfg.event_mask[0] = np_wdata;
        A_MSK1L: state_nxt.cfg.event_mask[1] = np_wdata;
        A_MSK2U: state_nxt.cfg.event_mask[2] = np_wdata;
        A_MSK2L: state_nxt.cfg.event_mask[3] = np_wdata;
        A_MSK3U: state_nxt.cfg.event_mask[4] = np_wdata;
        A_MSK3L: state_nxt.cfg.event_mask[5] = np_wdata;
        A_SHORT_IND: state_nxt.cfg.short_ind = np_wdata;
        A_LONG_IND_H: state_nxt.cfg.long_ind[47:32] = np_wdata;
        A_LONG_IND_M: state_nxt.cfg.long_ind[31:16] = np_wdata;
        A_LONG_IND_L: state_nxt.cfg.long_ind[15:0] = np_wdata;
        A_SHORT_GRP: state_nxt.cfg.short_grp = np_wdata;
        A_LONG_GRP_H: state_nxt.cfg.long_grp[47:32] = np_wdata;
        A_LONG_GRP_M: state_nxt.cfg.long_grp[31:16] = np_wdata;
        A_LONG_GRP_L: state_nxt.cfg.long_grp[15:0] = np_wdata;
        A_CFG1: state_nxt.cfg.config_one = np_wdata;
        A_CFG2: state_nxt.cfg.config_two = np_wdata;
        A_CFG3: state_nxt.cfg.config_three = np_wdata;
        A_MAX_ROT: state_nxt.cfg.max_rotation = np_wdata;
        A_TVX: state_nxt.cfg.tvx_limit = np_wdata;
        A_REQ_LO: state_nxt.cfg.req_rot_low = np_wdata;
        A_REQ_HI: state_nxt.cfg.req_rot_high = np_wdata[RMRD_LOW_W-1:0];
        A_PRI0: state_nxt.cfg.async_pri0 = np_wdata;
        A_PRI1: state_nxt.cfg.async_pri1 = np_wdata;
        A_SYNC_BW: state_nxt.cfg.sync_bw = np_wdata;
        A_FRM_THR: state_nxt.cfg.frame_thr = np_wdata;
        A_SYNC_LIM: state_nxt.cfg.sync_limit = np_wdata;
        // a counter write keeps a coincident increment rather than losing it
        A_CNT_FRAME: state_nxt.count[0] = np_wdata + {15'h0000, core.count_inc[0]};
        A_CNT_LOST: state_nxt.count[1] = np_wdata + {15'h0000, core.count_inc[1]};
        A_CNT_ERR: state_nxt.count[2] = np_wdata + {15'h0000, core.count_inc[2]};
        A_CNT_STRIP: state_nxt.count[3] = np_wdata + {15'h0000, core.count_inc[3]};
        A_INT_VEC: state_nxt.cfg.int_vector = np_wdata;
        A_INT_SEL: state_nxt.cfg.int_select = np_wdata;
        default: state_nxt.rd_ack = state_nxt.rd_ack;
      endcase
    end
    if (sys_rst) begin
      state_nxt = '0;
      state_nxt.status[1] = RST_STATUS_ONE_LOWER;
      state_nxt.status[2] = RST_ST_UP;
      state_nxt.status[4] = RST_ST_UP;
      state_nxt.cfg.event_mask = {6{RST_MASK}};
      state_nxt.cfg.config_one = RST_CFG1;
      state_nxt.cfg.config_two = RST_CFG2;
      state_nxt.cfg.max_rotation = RST_ROT_UP;
      state_nxt.cfg.tvx_limit = RST_TVX;
      state_nxt.tvx_tmr = RST_TVX;
      state_nxt.rot = {RST_ROT_UP, RST_LOW_ZERO};
      state_nxt.neg = {RST_ROT_UP, RST_LOW_ZERO};
      state_nxt.hold = {RST_HOLD_UP, RST_LOW_ONES};
      state_nxt.late = RST_LATE;
      state_nxt.cfg.req_rot_low = RST_REQ_LO;
      state_nxt.cfg.req_rot_high = RST_REQ_HI;
      state_nxt.cfg.async_pri0 = RST_PRI;
      state_nxt.cfg.async_pri1 = RST_PRI;
      state_nxt.cfg.sync_limit = RST_SYNC_LIM;
    end
  end

  always_ff @(posedge clock) begin
    state_r <= state_nxt;
  end

  assign np_rdata = state_r.rdata;
  assign np_rd_ack = state_r.rd_ack;
  assign cfg = state_r.cfg;
  assign cmd = state_r.cmd;
  assign requested_rotation = {state_r.cfg.req_rot_high, state_r.cfg.req_rot_low};
  // the sync-limit timer has no writable low bits; they stay zero
  assign sync_limit_timer = {state_r.cfg.sync_limit, RST_LOW_ZERO};
  assign rotation_timer = state_r.rot;
  assign holding_timer = state_r.hold;
  assign negotiated_rotation = state_r.neg;
  assign tvx_timer = state_r.tvx_tmr;

endmodule // rmrd_bank
